// >>> design/sfpi_front.sv
`timescale 1ns/10ps
`include "sfpi_regs.svh"
module sfpi_front
  import sfpi_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic                  rst_b,
  input  wire logic                  clk_en,
  input  wire logic [3:0]            reg_addr,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [7:0]            reg_rdata,
  input  wire logic                  cs_n_pin,
  input  wire logic                  sclk_pin,
  input  wire logic [3:0]            io_in,
  output logic      [3:0]            io_out,
  output logic      [3:0]            io_oe_n,
  input  wire logic                  op_busy,
  input  wire sfpi_pkg::sfpi_lane_e  lane_mode,
  input  wire logic                  tx_en,
  input  wire logic [7:0]            tx_byte,
  output logic                       tx_take,
  output logic                       rx_valid,
  output sfpi_pkg::sfpi_rx_s         rx_word,
  output sfpi_pkg::sfpi_map_s        addr_map,
  output logic                       addr_valid,
  output logic                       frame_abort,
  output logic                       standby,
  output logic                       paused,
  output logic                       hw_reset_n,
  output logic                       wsr_lock,
  output logic                       array_lock,
  output logic                       quad_reject
);
  import sfpi_pkg::*;

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [5:0]  s1_q;
  logic [5:0]  s2_q;
  logic [5:0]  s3_q;
  logic        cs_n_s;
  logic        sclk_s;
  logic [3:0]  io_s;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        cs_fall;

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s1_q <= 6'h3F;
      s2_q <= 6'h3F;
      s3_q <= 6'h3F;
    end
    else if (clk_en)
    begin
      s1_q <= {cs_n_pin, sclk_pin, io_in};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign cs_n_s    = s2_q[5];
  assign sclk_s    = s2_q[4];
  assign io_s      = s2_q[3:0];
  assign sclk_rise = sclk_s & ~s3_q[4];
  assign sclk_fall = ~sclk_s & s3_q[4];
  assign cs_fall   = ~cs_n_s & s3_q[5];

  // ****************************************
  // status registers
  // ****************************************
  logic [7:0]  status_reg_one_q;
  logic [7:0]  status_reg_two_q;
  logic [7:0]  status_reg_three_q;
  logic        quad_enable_bit;
  logic        prs;
  logic        wp_fn;
  logic        pause_fn;
  logic        reset_fn;

  assign quad_enable_bit = status_reg_two_q[`SFPI_QUAD_EN_BIT];
  assign prs             = status_reg_three_q[`SFPI_PRS_BIT];
  // undriven pin resolves high, no lock
  assign wp_fn    = ~quad_enable_bit & ~io_s[2];
  // quad enable leaves line 3 data only
  // select bit picks pause or reset
  assign pause_fn = ~quad_enable_bit & ~prs;
  assign reset_fn = ~quad_enable_bit & prs;

  assign wsr_lock   = wp_fn & ~status_reg_two_q[`SFPI_SRP_HI_BIT]
                    & status_reg_one_q[`SFPI_SRP_LO_BIT];
  assign array_lock = wsr_lock;

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      status_reg_one_q   <= `SFPI_STATUS_ONE_RST;
      status_reg_two_q   <= `SFPI_STATUS_TWO_RST;
      status_reg_three_q <= `SFPI_STATUS_THREE_RST;
    end
    else if (clk_en && reg_wr && !wsr_lock)
    begin
      unique case (reg_addr)
        `SFPI_REG_STATUS_ONE:   status_reg_one_q   <= reg_wdata;
        `SFPI_REG_STATUS_TWO:   status_reg_two_q   <= reg_wdata;
        `SFPI_REG_STATUS_THREE: status_reg_three_q <= reg_wdata;
        default:       ;
      endcase
    end
  end

  // ****************************************
  // interface state
  // ****************************************
  sfpi_state_e st_q;
  sfpi_state_e st_d;
  logic        hold_low;
  logic        rst_low;
  logic        shift_ok;

  assign hold_low = pause_fn & ~io_s[3];
  assign rst_low  = reset_fn & ~io_s[3];

  always_comb
  begin
    st_d = st_q;
    unique case (st_q)
      SFPI_ST_UNARMED:
      begin
        // first select fall arms the port
        if (cs_fall && !rst_low)
          st_d = SFPI_ST_ACTIVE;
      end
      SFPI_ST_IDLE:
      begin
        if (cs_fall && !rst_low)
          st_d = SFPI_ST_ACTIVE;
      end
      SFPI_ST_ACTIVE:
      begin
        if (cs_n_s || rst_low)
          st_d = SFPI_ST_IDLE;
        else if (hold_low && !sclk_s)
          st_d = SFPI_ST_PAUSED;
      end
      SFPI_ST_PAUSED:
      begin
        if (cs_n_s || rst_low)
          st_d = SFPI_ST_IDLE;
        else if (!hold_low && !sclk_s)
          st_d = SFPI_ST_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      st_q <= SFPI_ST_UNARMED;
    else if (clk_en)
      st_q <= st_d;
  end

  assign shift_ok = (st_q == SFPI_ST_ACTIVE) & ~cs_n_s & ~rst_low;

  // ****************************************
  // lane width
  // ****************************************
  sfpi_lane_e  lane;
  logic [3:0]  step;

  assign quad_reject = (lane_mode == SFPI_LANE_4) & ~quad_enable_bit;
  assign lane        = quad_reject ? SFPI_LANE_1 : lane_mode;

  always_comb
  begin
    unique case (lane)
      SFPI_LANE_2: step = `SFPI_STEP_2;
      SFPI_LANE_4: step = `SFPI_STEP_4;
      default:     step = `SFPI_STEP_1;
    endcase
  end

  function automatic logic [3:0] lane_bits(
    input logic [7:0] b,
    input sfpi_lane_e m
  );
    logic [3:0] r;
    r = 4'h0;
    unique case (m)
      SFPI_LANE_2: r = {2'h0, b[7:6]};
      SFPI_LANE_4: r = b[7:4];
      default:     r = {2'h0, b[7], 1'h0};
    endcase
    return r;
  endfunction

  // ****************************************
  // receive shifter
  // ****************************************
  logic [7:0]  rx_sh_q;
  logic [3:0]  rx_cnt_q;
  logic [3:0]  rx_sum;
  logic [7:0]  rx_next;
  logic [1:0]  byte_idx_q;

  assign rx_sum = rx_cnt_q + step;

  always_comb
  begin
    unique case (lane)
      SFPI_LANE_2: rx_next = {rx_sh_q[5:0], io_s[1:0]};
      SFPI_LANE_4: rx_next = {rx_sh_q[3:0], io_s};
      default:     rx_next = {rx_sh_q[6:0], io_s[0]};
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rx_sh_q    <= 8'h00;
      rx_cnt_q   <= 4'h0;
      byte_idx_q <= 2'h0;
      rx_valid   <= 1'h0;
      rx_word    <= '0;
    end
    else if (clk_en)
    begin
      rx_valid <= 1'h0;
      if (cs_n_s)
      begin
        rx_cnt_q   <= 4'h0;
        byte_idx_q <= 2'h0;
      end
      // quad lane captures on all lines, dual on lines 0 and 1
      else if (shift_ok && sclk_rise)
      begin
        rx_sh_q <= rx_next;
        if (rx_sum == `SFPI_BYTE_BITS)
        begin
          rx_cnt_q <= 4'h0;
          if (byte_idx_q != `SFPI_ADDR_LAST)
            byte_idx_q <= byte_idx_q + 2'h1;
          if (!tx_en)
          begin
            rx_valid      <= 1'h1;
            rx_word.data  <= rx_next;
            rx_word.index <= byte_idx_q;
          end
        end
        else
          rx_cnt_q <= rx_sum;
      end
    end
  end

  // ****************************************
  // address capture and decode
  // ****************************************
  logic [23:0] addr_q;

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      addr_q     <= 24'h000000;
      addr_map   <= '0;
      addr_valid <= 1'h0;
    end
    else if (clk_en)
    begin
      if (cs_n_s)
        addr_valid <= 1'h0;
      else if (rx_valid && rx_word.index != 2'h0)
      begin
        addr_q <= {addr_q[15:0], rx_word.data};
        if (rx_word.index == `SFPI_ADDR_LAST)
        begin
          addr_valid      <= 1'h1;
          addr_map.big    <= addr_q[`SFPI_BIG_HI-8:`SFPI_BIG_LO-8];
          addr_map.block  <= addr_q[`SFPI_BIG_HI-8:`SFPI_BLK_LO-8];
          addr_map.half   <= {addr_q[`SFPI_BIG_HI-8:`SFPI_BLK_LO-8],
                              addr_q[`SFPI_HALF_LO-8]};
          addr_map.sector <= {addr_q[`SFPI_BIG_HI-8:`SFPI_BLK_LO-8],
                              addr_q[`SFPI_HALF_LO-8:`SFPI_SECT_LO-8]};
        end
      end
    end
  end

  // ****************************************
  // transmit shifter
  // ****************************************
  logic [7:0]  tx_sh_q;
  logic [3:0]  tx_cnt_q;
  logic [3:0]  tx_sum;
  logic        drive_q;
  sfpi_lane_e  drv_lane_q;

  assign tx_sum = tx_cnt_q + step;

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tx_sh_q    <= 8'h00;
      tx_cnt_q   <= 4'h0;
      tx_take    <= 1'h0;
      drive_q    <= 1'h0;
      drv_lane_q <= SFPI_LANE_1;
      io_out     <= 4'h0;
    end
    else if (clk_en)
    begin
      tx_take <= 1'h0;
      if (cs_n_s || !tx_en)
      begin
        drive_q  <= 1'h0;
        tx_cnt_q <= 4'h0;
      end
      // single mode shifts on line 1
      else if (shift_ok && sclk_fall)
      begin
        drive_q    <= 1'h1;
        drv_lane_q <= lane;
        if (tx_cnt_q == 4'h0)
        begin
          tx_sh_q <= tx_byte;
          tx_take <= 1'h1;
          io_out  <= lane_bits(tx_byte, lane);
        end
        else
        begin
          tx_sh_q <= tx_sh_q << step;
          io_out  <= lane_bits(8'(tx_sh_q << step), lane);
        end
        tx_cnt_q <= (tx_sum == `SFPI_BYTE_BITS) ? 4'h0 : tx_sum;
      end
    end
  end

  // ****************************************
  // pin drivers
  // ****************************************
  logic        drv_on;

  assign drv_on = drive_q & ~cs_n_s & (st_q == SFPI_ST_ACTIVE);

  always_comb
  begin
    io_oe_n = 4'hF;
    if (drv_on)
    begin
      unique case (drv_lane_q)
        SFPI_LANE_2: io_oe_n = 4'hC;
        SFPI_LANE_4: io_oe_n = 4'h0;
        default:     io_oe_n = 4'hD;
      endcase
    end
  end

  // ****************************************
  // status outputs
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      frame_abort <= 1'h0;
      hw_reset_n  <= 1'h1;
    end
    else if (clk_en)
    begin
      // abort pulse on deselect in pause
      frame_abort <= (st_q == SFPI_ST_PAUSED) & cs_n_s;
      hw_reset_n  <= ~rst_low;
    end
  end

  // standby when deselected and not busy
  assign standby = cs_n_s & ~op_busy;
  assign paused  = (st_q == SFPI_ST_PAUSED);

  // ****************************************
  // register read port
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      reg_rdata <= 8'h00;
    else if (clk_en)
    begin
      reg_rdata <= 8'h00;
      if (reg_rd)
      begin
        unique case (reg_addr)
          `SFPI_REG_STATUS_ONE:   reg_rdata <= status_reg_one_q;
          `SFPI_REG_STATUS_TWO:   reg_rdata <= status_reg_two_q;
          `SFPI_REG_STATUS_THREE: reg_rdata <= status_reg_three_q;
          `SFPI_REG_STAT: reg_rdata <= {1'h0, op_busy, wsr_lock,
                                        ~hw_reset_n, standby, st_q, ~cs_n_s};
          default:        reg_rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule

// >>> design/sfpi_regs.svh
`ifndef SFPI_REGS_SVH
`define SFPI_REGS_SVH
// ****************************************
// register offsets
// ****************************************
`define SFPI_REG_STATUS_ONE   4'h0
`define SFPI_REG_STATUS_TWO   4'h1
`define SFPI_REG_STATUS_THREE 4'h2
`define SFPI_REG_STAT     4'h3
// ****************************************
// field positions and reset values
// ****************************************
`define SFPI_SRP_LO_BIT   7
`define SFPI_SRP_HI_BIT   0
`define SFPI_QUAD_EN_BIT  1
`define SFPI_PRS_BIT      0
`define SFPI_STATUS_ONE_RST   8'h00
`define SFPI_STATUS_TWO_RST   8'h00
`define SFPI_STATUS_THREE_RST 8'h00
// ****************************************
// serial byte and address layout
// ****************************************
`define SFPI_BYTE_BITS    4'h8
`define SFPI_STEP_1       4'h1
`define SFPI_STEP_2       4'h2
`define SFPI_STEP_4       4'h4
`define SFPI_ADDR_LAST    2'h3
`define SFPI_BIG_HI       21
`define SFPI_BIG_LO       20
`define SFPI_BLK_LO       16
`define SFPI_HALF_LO      15
`define SFPI_SECT_LO      12
`endif

// >>> design/sfpi_pkg.sv
package sfpi_pkg;
  typedef enum logic [1:0] {
    SFPI_LANE_1 = 2'h0,
    SFPI_LANE_2 = 2'h1,
    SFPI_LANE_4 = 2'h3
  } sfpi_lane_e;

  typedef enum logic [1:0] {
    SFPI_ST_UNARMED = 2'h0,
    SFPI_ST_IDLE    = 2'h1,
    SFPI_ST_ACTIVE  = 2'h3,
    SFPI_ST_PAUSED  = 2'h2
  } sfpi_state_e;

  typedef struct packed {
    logic [7:0] data;
    logic [1:0] index;
  } sfpi_rx_s;

  typedef struct packed {
    logic [1:0] big;
    logic [5:0] block;
    logic [6:0] half;
    logic [9:0] sector;
  } sfpi_map_s;
endpackage

// >>> bench/sfpi_front_asserts.sv
`timescale 1ns/10ps
// ********
// port checker
// ********
module sfpi_front_asserts
(
  input wire logic                 core_clk,
  input wire logic                 rst_b,
  input wire logic                 clk_en,
  input wire logic                 reg_rd,
  input wire logic [7:0]           reg_rdata,
  input wire logic                 cs_n_pin,
  input wire logic                 sclk_pin,
  input wire logic [3:0]           io_in,
  input wire logic [3:0]           io_out,
  input wire logic [3:0]           io_oe_n,
  input wire logic                 op_busy,
  input wire sfpi_pkg::sfpi_lane_e lane_mode,
  input wire logic                 rx_valid,
  input wire logic                 frame_abort,
  input wire logic                 standby,
  input wire logic                 paused,
  input wire logic                 wsr_lock,
  input wire logic                 array_lock,
  input wire logic                 quad_reject
);
  import sfpi_pkg::*;
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  sequence s_desel;
    cs_n_pin [*5];
  endsequence
  sequence s_sel;
    !cs_n_pin [*5];
  endsequence
  a_desel_release: assert property (s_desel |-> io_oe_n == 4'hF)
    else $error("driver on while deselected");
  a_standby_idle: assert property (s_desel ##0 !op_busy |-> standby)
    else $error("no standby");
  a_select_active: assert property (s_sel |-> !standby)
    else $error("standby while selected");
  a_quad_gate: assert property (quad_reject |-> io_oe_n[2] && io_oe_n[3])
    else $error("quad reject outside quad");
  a_lock_pair: assert property (array_lock == wsr_lock)
    else $error("locks differ");
  a_rdata_idle: assert property (clk_en && !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data without read");
  a_rx_pulse: assert property (rx_valid |=> !rx_valid)
    else $error("rx pulse too long");
  a_pause_entry: assert property ($rose(paused) |-> !sclk_pin && !io_in[3])
    else $error("pause began wrongly");
  a_pause_exit: assert property ($fell(paused) && !cs_n_pin |-> !sclk_pin && io_in[3])
    else $error("pause ended wrongly");
  a_abort_cause: assert property (frame_abort |-> $past(paused))
    else $error("abort without pause");
  a_out_low_clock: assert property ($changed(io_out) && !cs_n_pin |-> !$past(sclk_pin))
    else $error("output moved with clock high");
  a_single_lanes: assert property (lane_mode == SFPI_LANE_1 |-> io_oe_n[0] && &io_oe_n[3:2])
    else $error("extra line driven");
endmodule

bind sfpi_front sfpi_front_asserts u_chk
(
  .core_clk, .rst_b, .clk_en, .reg_rd, .reg_rdata, .cs_n_pin, .sclk_pin, .io_in,
  .io_out, .io_oe_n, .op_busy, .lane_mode, .rx_valid, .frame_abort, .standby,
  .paused, .wsr_lock, .array_lock, .quad_reject
);

// >>> bench/sfpi_host.sv
`timescale 1ns/10ps
// ********
// host serial controller
// ********
module sfpi_host
(
  input  wire logic       core_clk,
  input  wire logic [3:0] io,
  output logic            cs_n,
  output logic            sclk,
  output logic [3:0]      drv,
  output logic [3:0]      dout
);
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b1;
    drv  = 4'h0;
    dout = 4'h0;
  end
  task automatic sel(input logic v);
    cs_n <= v;
    repeat (6) @(posedge core_clk);
  endtask
  task automatic clk(input logic v);
    sclk <= v;
    repeat (6) @(posedge core_clk);
  endtask
  task automatic line(input int k, input logic d, input logic v);
    drv[k]  <= d;
    dout[k] <= v;
    repeat (6) @(posedge core_clk);
  endtask
  task automatic xfer(input logic [7:0] tx, input int n, input logic rd, output logic [7:0] rx);
    for (int i = 0; i < 8 / n; i++)
    begin
      sclk    <= 1'b0;
      drv[0]  <= !rd;
      dout[0] <= tx[7 - i];
      repeat (4) @(posedge core_clk);
      sclk <= 1'b1;
      repeat (4) @(posedge core_clk);
      rx = n == 1 ? {rx[6:0], io[1]} : n == 2 ? {rx[5:0], io[1:0]} : {rx[3:0], io};
    end
  endtask
endmodule

// >>> bench/sfpi_front_tb.sv
`timescale 1ns/10ps
module sfpi_front_tb;
  import sfpi_pkg::*;
  logic        core_clk, rst_b, clk_en, reg_wr, reg_rd, op_busy, tx_en, cs_n, sclk;
  logic        tx_take, rx_valid, addr_valid, frame_abort, standby, paused;
  logic        hw_reset_n, wsr_lock, array_lock, quad_reject;
  logic [3:0]  reg_addr, io, drv, dout, io_out, io_oe_n;
  logic [3:0]  io_q = 4'h0;
  logic [7:0]  reg_wdata, reg_rdata, tx_byte, b;
  logic [31:0] w;
  logic [11:0] rv [5] = '{12'h000, 12'h100, 12'h200, 12'hF00, 12'h308};
  logic [23:0] am [2] = '{24'h0F8000, 24'h3FF000};
  logic [7:0]  txv [3] = '{8'hC3, 8'h5A, 8'hE1};
  sfpi_lane_e  lane_mode;
  sfpi_lane_e  lm [3] = '{SFPI_LANE_1, SFPI_LANE_2, SFPI_LANE_4};
  sfpi_rx_s    rx_word;
  sfpi_map_s   addr_map;
  sfpi_rx_s    rxq [$];
  int          miscompares, check_count, aborts, takes;

  sfpi_front dut
  (
    .core_clk, .rst_b, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .cs_n_pin (cs_n), .sclk_pin (sclk), .io_in (io), .io_out, .io_oe_n, .op_busy,
    .lane_mode, .tx_en, .tx_byte, .tx_take, .rx_valid, .rx_word, .addr_map, .addr_valid,
    .frame_abort, .standby, .paused, .hw_reset_n, .wsr_lock, .array_lock, .quad_reject
  );
  sfpi_host host (.core_clk, .io, .cs_n, .sclk, .drv, .dout);

  // ********
  // wires, clock, monitors
  // ********
  always_comb
    for (int i = 0; i < 4; i++)
      io[i] = !io_oe_n[i] ? io_out[i] : drv[i] ? dout[i] : i > 1 || !io_q[i];
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    io_q <= io;
    if (rx_valid === 1'b1)
      rxq.push_back(rx_word);
    if (frame_abort === 1'b1)
      aborts++;
    if (tx_take === 1'b1)
      takes++;
  end
  initial
  begin
    repeat (10000) @(posedge core_clk);
    miscompares++;
    close_out();
  end

  // ********
  // tasks
  // ********
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    d = reg_rdata;
  endtask
  task automatic close_out();
    $display("comparisons %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ********
  // tests
  // ********
  initial
  begin
    rst_b     = 1'b0;
    clk_en    = 1'b1;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 4'h0;
    reg_wdata = 8'h00;
    op_busy   = 1'b0;
    tx_en     = 1'b0;
    tx_byte   = 8'hC3;
    lane_mode = SFPI_LANE_1;
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    foreach (rv[i])
    begin
      rd(rv[i][11:8], b);
      chk(b, rv[i][7:0]);
    end
    clk_en <= 1'b0;
    wr(4'h2, 8'h01);
    clk_en <= 1'b1;
    rd(4'h2, b);
    chk(b, 8'h00);
    host.xfer(8'hFF, 1, 1'b0, b);
    chk(rxq.size(), 0);
    foreach (am[j])
    begin
      w = {8'h0B, am[j]};
      host.clk(j == 0);
      host.sel(1'b0);
      rd(4'h3, b);
      chk(b, 8'h07);
      for (int k = 0; k < 4; k++)
        host.xfer(w[31 - 8 * k -: 8], 1, 1'b0, b);
      repeat (2) @(posedge core_clk);
      chk(addr_valid, 1'b1);
      chk(addr_map.sector, w[21:12]);
      chk(addr_map.block, w[21:16]);
      chk(addr_map.half, w[21:15]);
      chk(addr_map.big, w[21:20]);
      chk(rxq.size(), 4);
      for (int k = 0; k < 4; k++)
        chk(rxq[k], {w[31 - 8 * k -: 8], k[1:0]});
      rxq.delete();
      host.clk(j == 0);
      host.sel(1'b1);
    end
    host.clk(1'b1);
    lane_mode <= SFPI_LANE_4;
    repeat (2) @(posedge core_clk);
    chk(quad_reject, 1'b1);
    wr(4'h0, 8'h80);
    host.line(2, 1'b1, 1'b0);
    chk(array_lock, 1'b1);
    wr(4'h0, 8'h00);
    rd(4'h0, b);
    chk(b, 8'h80);
    host.line(2, 1'b0, 1'b0);
    chk(wsr_lock, 1'b0);
    wr(4'h1, 8'h02);
    host.line(2, 1'b1, 1'b0);
    chk(wsr_lock, 1'b0);
    chk(quad_reject, 1'b0);
    host.line(2, 1'b0, 1'b0);
    tx_en <= 1'b1;
    foreach (lm[j])
    begin
      lane_mode <= lm[j];
      tx_byte   <= txv[j];
      host.sel(1'b0);
      host.xfer(8'h00, 1 << j, 1'b1, b);
      chk(b, txv[j]);
      host.sel(1'b1);
    end
    chk(takes, 3);
    tx_en     <= 1'b0;
    lane_mode <= SFPI_LANE_1;
    wr(4'h1, 8'h00);
    host.sel(1'b0);
    host.line(3, 1'b1, 1'b0);
    chk(paused, 1'b0);
    host.clk(1'b0);
    chk(paused, 1'b1);
    op_busy <= 1'b1;
    host.clk(1'b1);
    host.line(3, 1'b0, 1'b0);
    chk(paused, 1'b1);
    host.clk(1'b0);
    chk(paused, 1'b0);
    host.line(3, 1'b1, 1'b0);
    host.sel(1'b1);
    chk(aborts, 1);
    chk(standby, 1'b0);
    op_busy <= 1'b0;
    host.clk(1'b1);
    host.line(3, 1'b0, 1'b0);
    chk(standby, 1'b1);
    wr(4'h2, 8'h01);
    host.line(3, 1'b1, 1'b0);
    chk(hw_reset_n, 1'b0);
    wr(4'h1, 8'h02);
    repeat (2) @(posedge core_clk);
    chk(hw_reset_n, 1'b1);
    host.line(3, 1'b0, 1'b0);
    close_out();
  end
endmodule
